// ==== hdl/pad_decoder.sv ====
`include "pad_regs.svh"
// ***********************************************************
// Physical address decoder
// ***********************************************************
module pad_decoder #(
  parameter int ADDR_W = 32
) (
  input  wire logic                    CORE_CLK_I,
  input  wire logic                    RESET_I,
  input  wire logic                    REQ_VALID_I,
  input  wire logic                    REQ_WRITE_I,
  input  wire logic [ADDR_W-1:0]       REQ_ADDR_I,
  input  wire logic                    SYNC_BOOT_ROM_SELECT_I,
  input  wire logic                    BOOT_ROM_WIDE_I,
  output logic                         DONE_O,
  output pad_pkg::pad_target_t         TARGET_O,
  output logic [`PAD_NUM_STATIC-1:0]   STATIC_BANK_SELECTS_O,
  output logic                         STATIC_VAR_LATENCY_O,
  output logic [`PAD_NUM_DRAM-1:0]     DRAM_BANK_STROBES_O,
  output logic [`PAD_NUM_REGBLK-1:0]   REG_BLOCK_SELECTS_O,
  output logic                         SOCKET_SELECT_O,
  output logic [1:0]                   SOCKET_SPACE_O,
  output logic [`PAD_EXT_ADDR_W-1:0]   EXT_ADDR_O,
  output logic                         BOOT_ROM_SYNC_O,
  output logic                         BOOT_ROM_WIDE_O,
  output logic                         STRAP_ERROR_O,
  output logic                         ZERO_DATA_O,
  output logic                         WRITE_DROPPED_O,
  output logic                         DATA_ABORT_O
);

  // The region and window split is tied to a 32-bit physical space.
  if (ADDR_W != 32) begin : g_addr_w_check
    $error("pad_decoder serves only a 32-bit address");
  end

  // ***********************************************************
  // Strap capture
  // ***********************************************************
  // Straps are caught on the first edge after reset release, so reset itself loads only constants.
  logic strap_taken_r, strap_taken_nxt;
  logic rom_sync_r, rom_sync_nxt;
  logic rom_wide_r, rom_wide_nxt;
  logic strap_err_r, strap_err_nxt;

  always_comb begin
    strap_taken_nxt = 1'b1;
    rom_sync_nxt    = rom_sync_r;
    rom_wide_nxt    = rom_wide_r;
    strap_err_nxt   = strap_err_r;
    if (!strap_taken_r) begin
      rom_sync_nxt  = SYNC_BOOT_ROM_SELECT_I;
      // A synchronous boot ROM is always served as 32 bits wide.
      rom_wide_nxt  = SYNC_BOOT_ROM_SELECT_I | BOOT_ROM_WIDE_I;
      strap_err_nxt = SYNC_BOOT_ROM_SELECT_I & ~BOOT_ROM_WIDE_I;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      strap_taken_r <= 1'b0;
      rom_sync_r    <= 1'b0;
      rom_wide_r    <= 1'b0;
      strap_err_r   <= 1'b0;
    end else begin
      strap_taken_r <= strap_taken_nxt;
      rom_sync_r    <= rom_sync_nxt;
      rom_wide_r    <= rom_wide_nxt;
      strap_err_r   <= strap_err_nxt;
    end
  end

  // ***********************************************************
  // Address decode
  // ***********************************************************
  function automatic logic [3:0] pad_onehot4(input logic [1:0] idx);
    pad_onehot4 = 4'h1 << idx;
  endfunction

  pad_pkg::pad_target_t              tgt_c;
  logic [`PAD_NUM_STATIC-1:0]        cs_c;
  logic [`PAD_NUM_DRAM-1:0]          dram_c;
  logic [`PAD_NUM_REGBLK-1:0]        regblk_c;
  logic                              sock_c;
  logic [1:0]                        space_c;
  logic [`PAD_EXT_ADDR_W-1:0]        ext_c;
  logic [2:0]                        sub;

  always_comb begin
    sub      = REQ_ADDR_I[`PAD_SUB_MSB:`PAD_SUB_LSB];
    tgt_c    = pad_pkg::PAD_TGT_NONE;
    cs_c     = '0;
    dram_c   = '0;
    regblk_c = '0;
    sock_c   = 1'b0;
    space_c  = 2'h0;
    ext_c    = '0;
    if (REQ_ADDR_I[`PAD_REGION_MSB:`PAD_REGION_LSB] == `PAD_REG_ROW) begin
      if (!sub[2]) begin
        tgt_c = pad_pkg::PAD_TGT_STATIC;
        cs_c  = {2'h0, pad_onehot4(sub[1:0])};
        // Bit 26 never reaches a pin, so the upper half aliases the lower.
        ext_c = REQ_ADDR_I[`PAD_EXT_ADDR_W-1:0];
      end else begin
        tgt_c   = pad_pkg::PAD_TGT_SOCKET;
        sock_c  = REQ_ADDR_I[`PAD_SOCK_BIT];
        space_c = REQ_ADDR_I[`PAD_SPACE_MSB:`PAD_SPACE_LSB];
        ext_c   = REQ_ADDR_I[`PAD_EXT_ADDR_W-1:0];
      end
    end else if (REQ_ADDR_I[`PAD_REGION_MSB:`PAD_REGION_LSB] == `PAD_REG_VAR) begin
      if (sub[2:1] == 2'h0) begin
        tgt_c = pad_pkg::PAD_TGT_STATIC;
        cs_c  = sub[0] ? 6'h20 : 6'h10;
        ext_c = REQ_ADDR_I[`PAD_EXT_ADDR_W-1:0];
      end else begin
        tgt_c = pad_pkg::PAD_TGT_ABORT;
      end
    end else if (REQ_ADDR_I[`PAD_REGION_MSB:`PAD_REGION_LSB] == `PAD_REG_REGS) begin
      tgt_c    = pad_pkg::PAD_TGT_REGS;
      regblk_c = pad_onehot4(REQ_ADDR_I[`PAD_REGBLK_MSB:`PAD_REGBLK_LSB]);
    end else begin
      if (!sub[2]) begin
        tgt_c  = pad_pkg::PAD_TGT_DRAM;
        dram_c = pad_onehot4(sub[1:0]);
      end else if (sub == 3'h4) begin
        tgt_c = pad_pkg::PAD_TGT_ZERO;
      end else begin
        tgt_c = pad_pkg::PAD_TGT_ABORT;
      end
    end
  end

  // ***********************************************************
  // Registered answer
  // ***********************************************************
  // One cycle of latency keeps every data output on a flip-flop.
  logic                              done_r, done_nxt;
  pad_pkg::pad_target_t              tgt_r, tgt_nxt;
  logic [`PAD_NUM_STATIC-1:0]        cs_r, cs_nxt;
  logic [`PAD_NUM_DRAM-1:0]          dram_r, dram_nxt;
  logic [`PAD_NUM_REGBLK-1:0]        regblk_r, regblk_nxt;
  logic                              sock_r, sock_nxt;
  logic [1:0]                        space_r, space_nxt;
  logic [`PAD_EXT_ADDR_W-1:0]        ext_r, ext_nxt;
  logic                              varlat_r, varlat_nxt;
  logic                              zero_r, zero_nxt;
  logic                              drop_r, drop_nxt;
  logic                              abort_r, abort_nxt;

  always_comb begin
    done_nxt   = REQ_VALID_I;
    tgt_nxt    = pad_pkg::PAD_TGT_NONE;
    cs_nxt     = '0;
    dram_nxt   = '0;
    regblk_nxt = '0;
    sock_nxt   = 1'b0;
    space_nxt  = 2'h0;
    ext_nxt    = ext_r;
    varlat_nxt = 1'b0;
    zero_nxt   = 1'b0;
    drop_nxt   = 1'b0;
    abort_nxt  = 1'b0;
    if (REQ_VALID_I) begin
      tgt_nxt    = tgt_c;
      cs_nxt     = cs_c;
      dram_nxt   = dram_c;
      regblk_nxt = regblk_c;
      sock_nxt   = sock_c;
      space_nxt  = space_c;
      ext_nxt    = ext_c;
      varlat_nxt = |cs_c[5:3];
      zero_nxt   = (tgt_c == pad_pkg::PAD_TGT_ZERO) && !REQ_WRITE_I;
      drop_nxt   = (tgt_c == pad_pkg::PAD_TGT_ZERO) && REQ_WRITE_I;
      abort_nxt  = (tgt_c == pad_pkg::PAD_TGT_ABORT);
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      done_r   <= 1'b0;
      tgt_r    <= pad_pkg::PAD_TGT_NONE;
      cs_r     <= '0;
      dram_r   <= '0;
      regblk_r <= '0;
      sock_r   <= 1'b0;
      space_r  <= 2'h0;
      ext_r    <= '0;
      varlat_r <= 1'b0;
      zero_r   <= 1'b0;
      drop_r   <= 1'b0;
      abort_r  <= 1'b0;
    end else begin
      done_r   <= done_nxt;
      tgt_r    <= tgt_nxt;
      cs_r     <= cs_nxt;
      dram_r   <= dram_nxt;
      regblk_r <= regblk_nxt;
      sock_r   <= sock_nxt;
      space_r  <= space_nxt;
      ext_r    <= ext_nxt;
      varlat_r <= varlat_nxt;
      zero_r   <= zero_nxt;
      drop_r   <= drop_nxt;
      abort_r  <= abort_nxt;
    end
  end

  assign DONE_O                = done_r;
  assign TARGET_O              = tgt_r;
  assign STATIC_BANK_SELECTS_O = cs_r;
  assign STATIC_VAR_LATENCY_O  = varlat_r;
  assign DRAM_BANK_STROBES_O   = dram_r;
  assign REG_BLOCK_SELECTS_O   = regblk_r;
  assign SOCKET_SELECT_O       = sock_r;
  assign SOCKET_SPACE_O        = space_r;
  assign EXT_ADDR_O            = ext_r;
  assign BOOT_ROM_SYNC_O       = rom_sync_r;
  assign BOOT_ROM_WIDE_O       = rom_wide_r;
  assign STRAP_ERROR_O         = strap_err_r;
  assign ZERO_DATA_O           = zero_r;
  assign WRITE_DROPPED_O       = drop_r;
  assign DATA_ABORT_O          = abort_r;

endmodule

// ==== hdl/pad_pkg.sv ====
package pad_pkg;
  typedef enum logic [2:0] {
    PAD_TGT_NONE   = 3'h0,
    PAD_TGT_STATIC = 3'h1,
    PAD_TGT_SOCKET = 3'h2,
    PAD_TGT_REGS   = 3'h3,
    PAD_TGT_DRAM   = 3'h4,
    PAD_TGT_ZERO   = 3'h5,
    PAD_TGT_ABORT  = 3'h6
  } pad_target_t;
endpackage

// ==== hdl/pad_regs.svh ====
`ifndef PAD_REGS_SVH
`define PAD_REGS_SVH
`define PAD_REGION_MSB     31
`define PAD_REGION_LSB     30
`define PAD_SUB_MSB        29
`define PAD_SUB_LSB        27
`define PAD_ALIAS_BIT      26
`define PAD_EXT_ADDR_W     26
`define PAD_SOCK_BIT       28
`define PAD_SPACE_MSB      27
`define PAD_SPACE_LSB      26
`define PAD_REGBLK_MSB     29
`define PAD_REGBLK_LSB     28
`define PAD_REG_ROW        2'h0
`define PAD_REG_VAR        2'h1
`define PAD_REG_REGS       2'h2
`define PAD_REG_DRAM       2'h3
`define PAD_NUM_STATIC     6
`define PAD_NUM_DRAM       4
`define PAD_NUM_REGBLK     4
`endif

// ==== tb/pad_core_model.sv ====
// ****
// Core request driver
// ****
module pad_core_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] addr_i,
  output logic             valid_o,
  output logic             write_o,
  output logic [31:0]      addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Launching on the falling edge keeps requests clear of the sampling edge.
  initial {valid_o, write_o, addr_o} = '0;
  always @(negedge clk_i) begin
    valid_o <= go_i;
    write_o <= wr_i;
    addr_o  <= addr_i;
  end
endmodule

// ==== tb/pad_decoder_properties.sv ====
// ****
// Decode checks
// ****
module pad_decoder_properties (
  input wire logic                 CORE_CLK_I,
  input wire logic                 RESET_I,
  input wire logic                 REQ_VALID_I,
  input wire logic                 REQ_WRITE_I,
  input wire logic [31:0]          REQ_ADDR_I,
  input wire logic                 DONE_O,
  input wire pad_pkg::pad_target_t TARGET_O,
  input wire logic [5:0]           STATIC_BANK_SELECTS_O,
  input wire logic [3:0]           DRAM_BANK_STROBES_O,
  input wire logic [3:0]           REG_BLOCK_SELECTS_O,
  input wire logic                 SOCKET_SELECT_O,
  input wire logic [25:0]          EXT_ADDR_O,
  input wire logic                 BOOT_ROM_SYNC_O,
  input wire logic                 BOOT_ROM_WIDE_O,
  input wire logic                 ZERO_DATA_O,
  input wire logic                 WRITE_DROPPED_O,
  input wire logic                 DATA_ABORT_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  wire       v = REQ_VALID_I;
  wire [31:0] a = REQ_ADDR_I;
  a_done_pulse: assert property (DONE_O == $past(v)) else $error("done mismatch");
  a_static_low: assert property (v && a[31:29] == 3'h0 |=>
    STATIC_BANK_SELECTS_O == 6'h1 << $past(a[28:27]) && EXT_ADDR_O == $past(a[25:0]))
    else $error("static select wrong");
  a_socket_sel: assert property (v && a[31:29] == 3'h1 |=> TARGET_O == pad_pkg::PAD_TGT_SOCKET
    && SOCKET_SELECT_O == $past(a[28])) else $error("socket wrong");
  a_var_window: assert property (v && a[31:28] == 4'h4 |=>
    STATIC_BANK_SELECTS_O == 6'h10 << $past(a[27])) else $error("upper select wrong");
  a_reserved_abort: assert property (v && (a[31:28] inside {4'h5, 4'h6, 4'h7} || a[31:27] >= 5'h1d)
    |=> DATA_ABORT_O) else $error("abort missing");
  a_reg_blocks: assert property (v && a[31:30] == 2'h2 |=>
    REG_BLOCK_SELECTS_O == 4'h1 << $past(a[29:28])) else $error("register block wrong");
  a_dram_bank: assert property (v && a[31:29] == 3'h6 |=>
    DRAM_BANK_STROBES_O == 4'h1 << $past(a[28:27])) else $error("dram bank wrong");
  a_zero_window: assert property (v && a[31:27] == 5'h1c |=> ZERO_DATA_O == !$past(REQ_WRITE_I)
    && WRITE_DROPPED_O == $past(REQ_WRITE_I)) else $error("zero window wrong");
  a_strap_legal: assert property (BOOT_ROM_SYNC_O |-> BOOT_ROM_WIDE_O) else $error("sync with narrow");
endmodule

bind pad_decoder pad_decoder_properties pad_decoder_properties_i (
  .CORE_CLK_I            (CORE_CLK_I),
  .RESET_I               (RESET_I),
  .REQ_VALID_I           (REQ_VALID_I),
  .REQ_WRITE_I           (REQ_WRITE_I),
  .REQ_ADDR_I            (REQ_ADDR_I),
  .DONE_O                (DONE_O),
  .TARGET_O              (TARGET_O),
  .STATIC_BANK_SELECTS_O (STATIC_BANK_SELECTS_O),
  .DRAM_BANK_STROBES_O   (DRAM_BANK_STROBES_O),
  .REG_BLOCK_SELECTS_O   (REG_BLOCK_SELECTS_O),
  .SOCKET_SELECT_O       (SOCKET_SELECT_O),
  .EXT_ADDR_O            (EXT_ADDR_O),
  .BOOT_ROM_SYNC_O       (BOOT_ROM_SYNC_O),
  .BOOT_ROM_WIDE_O       (BOOT_ROM_WIDE_O),
  .ZERO_DATA_O           (ZERO_DATA_O),
  .WRITE_DROPPED_O       (WRITE_DROPPED_O),
  .DATA_ABORT_O          (DATA_ABORT_O)
);

// ==== tb/pad_decoder_tb.sv ====
// ****
// Decoder bench
// ****
module pad_decoder_tb;
  timeunit 1ns;
  // A finer precision keeps the 12.5 ns half period exact.
  timeprecision 100ps;
  logic CORE_CLK_I = 0, RESET_I = 1, REQ_VALID_I, REQ_WRITE_I, SYNC_BOOT_ROM_SELECT_I = 0, BOOT_ROM_WIDE_I = 1;
  logic DONE_O, STATIC_VAR_LATENCY_O, SOCKET_SELECT_O, BOOT_ROM_SYNC_O, BOOT_ROM_WIDE_O, STRAP_ERROR_O;
  logic ZERO_DATA_O, WRITE_DROPPED_O, DATA_ABORT_O, go = 0, wr = 0;
  logic [31:0] REQ_ADDR_I, ad = 0, seed;
  logic [25:0] EXT_ADDR_O;
  logic [5:0]  STATIC_BANK_SELECTS_O;
  logic [3:0]  DRAM_BANK_STROBES_O, REG_BLOCK_SELECTS_O;
  logic [1:0]  SOCKET_SPACE_O;
  pad_pkg::pad_target_t TARGET_O, t;
  int err_count = 0, n_tests = 0, r;
  pad_decoder pad_decoder_i (
    .CORE_CLK_I             (CORE_CLK_I),
    .RESET_I                (RESET_I),
    .REQ_VALID_I            (REQ_VALID_I),
    .REQ_WRITE_I            (REQ_WRITE_I),
    .REQ_ADDR_I             (REQ_ADDR_I),
    .SYNC_BOOT_ROM_SELECT_I (SYNC_BOOT_ROM_SELECT_I),
    .BOOT_ROM_WIDE_I        (BOOT_ROM_WIDE_I),
    .DONE_O                 (DONE_O),
    .TARGET_O               (TARGET_O),
    .STATIC_BANK_SELECTS_O  (STATIC_BANK_SELECTS_O),
    .STATIC_VAR_LATENCY_O   (STATIC_VAR_LATENCY_O),
    .DRAM_BANK_STROBES_O    (DRAM_BANK_STROBES_O),
    .REG_BLOCK_SELECTS_O    (REG_BLOCK_SELECTS_O),
    .SOCKET_SELECT_O        (SOCKET_SELECT_O),
    .SOCKET_SPACE_O         (SOCKET_SPACE_O),
    .EXT_ADDR_O             (EXT_ADDR_O),
    .BOOT_ROM_SYNC_O        (BOOT_ROM_SYNC_O),
    .BOOT_ROM_WIDE_O        (BOOT_ROM_WIDE_O),
    .STRAP_ERROR_O          (STRAP_ERROR_O),
    .ZERO_DATA_O            (ZERO_DATA_O),
    .WRITE_DROPPED_O        (WRITE_DROPPED_O),
    .DATA_ABORT_O           (DATA_ABORT_O)
  );
  pad_core_model pad_core_model_i (.clk_i(CORE_CLK_I), .go_i(go), .wr_i(wr), .addr_i(ad),
    .valid_o(REQ_VALID_I), .write_o(REQ_WRITE_I), .addr_o(REQ_ADDR_I));
  initial forever #12.5 CORE_CLK_I = ~CORE_CLK_I;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic pad_pkg::pad_target_t exp_tgt(input logic [31:0] a);
    int q;
    q = a[31:28];
    if (q < 2 || q == 4) return pad_pkg::PAD_TGT_STATIC;
    if (q < 4) return pad_pkg::PAD_TGT_SOCKET;
    if (q < 8) return pad_pkg::PAD_TGT_ABORT;
    if (q < 12) return pad_pkg::PAD_TGT_REGS;
    if (q < 14) return pad_pkg::PAD_TGT_DRAM;
    if (q == 14 && !a[27]) return pad_pkg::PAD_TGT_ZERO;
    return pad_pkg::PAD_TGT_ABORT;
  endfunction
  task check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: saw %h, want %h", $time, s, e);
    end
  endtask
  task end_of_test;
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    end_of_test;
  end
  initial begin
    seed = 32'h00876e11;
    for (int i = 0; i < 4; i++) begin
      @(negedge CORE_CLK_I);
      {SYNC_BOOT_ROM_SELECT_I, BOOT_ROM_WIDE_I} = i[1:0];
      RESET_I = 1;
      repeat (10) @(negedge CORE_CLK_I);
      RESET_I = 0;
      // Straps are moved after capture to prove they are sampled only once.
      @(negedge CORE_CLK_I);
      {SYNC_BOOT_ROM_SELECT_I, BOOT_ROM_WIDE_I} = ~i[1:0];
      @(negedge CORE_CLK_I);
      check(BOOT_ROM_SYNC_O, i[1]);
      check(BOOT_ROM_WIDE_O, i[1] | i[0]);
      check(STRAP_ERROR_O, i == 2);
    end
    @(posedge CORE_CLK_I);
    #1;
    repeat (3000) begin
      seed = xs(seed);
      ad = seed;
      wr = seed[5];
      go = seed[9] | seed[10];
      t = go ? exp_tgt(ad) : pad_pkg::PAD_TGT_NONE;
      r = ad[31:28];
      repeat (2) @(posedge CORE_CLK_I);
      #1;
      check(DONE_O, go);
      check(TARGET_O, t);
      check(DATA_ABORT_O, t == pad_pkg::PAD_TGT_ABORT);
      check(ZERO_DATA_O, t == pad_pkg::PAD_TGT_ZERO && !wr);
      check(WRITE_DROPPED_O, t == pad_pkg::PAD_TGT_ZERO && wr);
      check(STATIC_BANK_SELECTS_O, t != pad_pkg::PAD_TGT_STATIC ? 0 : r < 2 ? 1 << ad[28:27] : 16 << ad[27]);
      check(STATIC_VAR_LATENCY_O, t == pad_pkg::PAD_TGT_STATIC && (r == 4 || ad[28:27] == 2'h3));
      check(DRAM_BANK_STROBES_O, t == pad_pkg::PAD_TGT_DRAM ? 1 << ad[28:27] : 0);
      check(REG_BLOCK_SELECTS_O, t == pad_pkg::PAD_TGT_REGS ? 1 << ad[29:28] : 0);
      if (t == pad_pkg::PAD_TGT_STATIC || t == pad_pkg::PAD_TGT_SOCKET) check(EXT_ADDR_O, ad[25:0]);
      if (t == pad_pkg::PAD_TGT_SOCKET) check({SOCKET_SELECT_O, SOCKET_SPACE_O}, ad[28:26]);
    end
    end_of_test;
  end
endmodule
